// >>> design/aerreg_pkg.sv
// Purpose: constants and carrier types for the error reporting capability register bank
// Assumes: dword-addressed configuration accesses, byte enables per lane
// Notes: sticky state survives the ordinary reset; only the power-on reset clears it
package aerreg_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses in configuration space)
	// ------------------------------------------------------------
	localparam logic [11:0] HDR_OFF = 12'h100;
	localparam logic [11:0] STAT_OFF = 12'h104;
	localparam logic [11:0] MASK_OFF = 12'h108;
	localparam logic [11:0] SEV_OFF = 12'h10C;

	// ------------------------------------------------------------
	// header fields
	// ------------------------------------------------------------
	localparam logic [15:0] CAP_ID = 16'h0001;
	localparam logic [3:0] CAP_VER = 4'h1;
	localparam logic [11:0] NEXT_WITH_DSN = 12'h140;
	localparam logic [11:0] NEXT_NO_DSN = 12'h150;

	// ------------------------------------------------------------
	// bit layouts of the uncorrectable registers
	// ------------------------------------------------------------
	localparam logic [31:0] ERR_SUPPORTED = 32'h0017_D010;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] STAT_RESET = 32'h0000_0000;
	localparam logic [31:0] SEV_RESET = 32'h0006_0010;
	localparam logic [31:0] SEV_FIXED_ONE = 32'h0000_2020;
	localparam logic [31:0] READ_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} aerreg_req_t;

	typedef struct packed {
		logic [31:0] stat;
		logic [31:0] mask;
		logic [31:0] sev;
	} aerreg_err_t;

endpackage

// >>> design/aerreg_sticky.sv
// Purpose: sticky uncorrectable status, mask and severity state
// Assumes: power-on reset separate from the ordinary reset
// Notes: set wins over a write-one-to-clear in the same cycle
`timescale 1ns/1ns
module aerreg_sticky (
	// clock and reset
	input wire logic clk_i,
	input wire logic por_rst_i,
	// write side
	input wire logic wr_i,
	input wire logic [31:0] wmask_i,
	input wire logic [31:0] wdata_i,
	input wire logic sel_stat_i,
	input wire logic sel_mask_i,
	input wire logic sel_sev_i,
	// error events
	input wire logic [31:0] err_set_i,
	// state
	output aerreg_pkg::aerreg_err_t state_o
);

	aerreg_pkg::aerreg_err_t st_reg;
	aerreg_pkg::aerreg_err_t st_next;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_comb begin
		st_next = st_reg;
		// write-one-to-clear, then new events; set beats clear
		if (wr_i && sel_stat_i) begin
			st_next.stat = st_reg.stat & ~(wdata_i & wmask_i);
		end
		st_next.stat = (st_next.stat | err_set_i) & aerreg_pkg::ERR_SUPPORTED;
		if (wr_i && sel_mask_i) begin
			st_next.mask = merge(st_reg.mask, wdata_i, wmask_i) & aerreg_pkg::ERR_SUPPORTED;
		end
		if (wr_i && sel_sev_i) begin
			st_next.sev = merge(st_reg.sev, wdata_i, wmask_i & aerreg_pkg::ERR_SUPPORTED);
		end
		st_next.sev = (st_next.sev & aerreg_pkg::ERR_SUPPORTED) | aerreg_pkg::SEV_FIXED_ONE;
	end

	always_ff @(posedge clk_i) begin
		if (por_rst_i) begin
			st_reg.stat <= aerreg_pkg::STAT_RESET;
			st_reg.mask <= aerreg_pkg::MASK_RESET;
			st_reg.sev <= aerreg_pkg::SEV_RESET | aerreg_pkg::SEV_FIXED_ONE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign state_o = st_reg;

	a_stat_set_wins: assert property (@(posedge clk_i) disable iff (por_rst_i)
		(err_set_i[4]) |=> st_reg.stat[4]) else $error("event lost on status bit 4");
	// every unsupported or reserved position, not only 5, 13 and 19
	a_unsup_zero: assert property (@(posedge clk_i) disable iff (por_rst_i)
		((st_reg.stat & ~aerreg_pkg::ERR_SUPPORTED) == 32'h0000_0000)
		&& ((st_reg.mask & ~aerreg_pkg::ERR_SUPPORTED) == 32'h0000_0000))
		else $error("unsupported bit not zero");
	a_sev_fixed: assert property (@(posedge clk_i) disable iff (por_rst_i)
		st_reg.sev[5] && st_reg.sev[13] && !st_reg.sev[19]) else $error("fixed severity bit wrong");
	a_mask_write: assert property (@(posedge clk_i) disable iff (por_rst_i)
		(wr_i && sel_mask_i && wmask_i[12]) |=> (st_reg.mask[12] == $past(wdata_i[12])))
		else $error("mask write not stored");

endmodule // aerreg_sticky

// >>> design/aerreg_top.sv
// Purpose: error reporting extended capability registers of the endpoint configuration space
// Assumes: configuration accesses arrive as one-cycle strobes on the core clock
// Notes: reads answer one cycle after the strobe; other offsets read zero and ignore writes
//
// Contract
// - the header low sixteen bits read the constant identifier one and ignore writes.
// - header bits 19 to 16 read the constant version one.
// - header bits 31 to 20 read 140h with the serial number structure enabled, else 150h.
// - status bits 4,12,14..18,20 are sticky, cleared by writing one, reset to zero.
// - status and mask bits 5, 13 and 19 read zero always.
// - mask bits at the supported positions are sticky read-write, reset to zero.
// - severity bits at the supported positions are sticky read-write, reset one at 4,17,18; 5 and 13 are fixed one, all others fixed zero.
`timescale 1ns/1ns
module aerreg_top (
	// clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic por_rst_i,
	// configuration access
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// structure straps and error events
	input wire logic dsn_structure_enable_i,
	input wire logic [31:0] err_event_i,
	// reported state
	output logic [31:0] err_pending_o,
	output logic [31:0] err_fatal_o
);

	aerreg_pkg::aerreg_req_t req;
	aerreg_pkg::aerreg_err_t st;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [31:0] pend_reg;
	logic [31:0] pend_next;
	logic [31:0] fatal_reg;
	logic [31:0] fatal_next;

	function automatic logic [31:0] be_expand(input logic [3:0] be);
		be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	assign req = '{rd: cfg_rd_i, wr: cfg_wr_i, addr: cfg_addr_i, be: cfg_be_i, wdata: cfg_wdata_i};
	assign wmask = be_expand(req.be);

	// ------------------------------------------------------------
	// sticky state, cleared only by power-on reset
	// ------------------------------------------------------------
	aerreg_sticky u_sticky (
		.clk_i(clk_i),
		.por_rst_i(por_rst_i),
		.wr_i(req.wr),
		.wmask_i(wmask),
		.wdata_i(req.wdata),
		.sel_stat_i(req.addr == aerreg_pkg::STAT_OFF),
		.sel_mask_i(req.addr == aerreg_pkg::MASK_OFF),
		.sel_sev_i(req.addr == aerreg_pkg::SEV_OFF),
		.err_set_i(err_event_i),
		.state_o(st)
	);

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	always_comb begin
		case (req.addr)
			aerreg_pkg::HDR_OFF: begin
				rd_word = {(dsn_structure_enable_i ? aerreg_pkg::NEXT_WITH_DSN : aerreg_pkg::NEXT_NO_DSN),
					aerreg_pkg::CAP_VER,
					aerreg_pkg::CAP_ID};
			end
			aerreg_pkg::STAT_OFF: rd_word = st.stat & aerreg_pkg::ERR_SUPPORTED;
			aerreg_pkg::MASK_OFF: rd_word = st.mask & aerreg_pkg::ERR_SUPPORTED;
			aerreg_pkg::SEV_OFF: rd_word = st.sev;
			default: rd_word = aerreg_pkg::READ_RESET;
		endcase
	end

	always_comb begin
		rvalid_next = req.rd;
		rdata_next = req.rd ? rd_word : aerreg_pkg::READ_RESET;
		// unmasked pending errors, split by severity for the message logic
		pend_next = st.stat & ~st.mask;
		fatal_next = st.stat & ~st.mask & st.sev;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_reg <= aerreg_pkg::READ_RESET;
			rvalid_reg <= 1'b0;
			pend_reg <= aerreg_pkg::READ_RESET;
			fatal_reg <= aerreg_pkg::READ_RESET;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			pend_reg <= pend_next;
			fatal_reg <= fatal_next;
		end
	end

	assign cfg_rdata_o = rdata_reg;
	assign cfg_rvalid_o = rvalid_reg;
	assign err_pending_o = pend_reg;
	assign err_fatal_o = fatal_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence hdr_read;
		cfg_rd_i && cfg_addr_i == aerreg_pkg::HDR_OFF;
	endsequence

	// clear of bit 12 with no competing event on that bit
	sequence stat_clear_req;
		cfg_wr_i && cfg_addr_i == aerreg_pkg::STAT_OFF && cfg_be_i[1] && cfg_wdata_i[12] && !err_event_i[12];
	endsequence

	a_hdr_id: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		hdr_read |=> cfg_rvalid_o && cfg_rdata_o[19:0] == 20'h1_0001) else $error("header id or version wrong");
	a_hdr_ver: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		hdr_read |=> cfg_rdata_o[19:16] == 4'h1) else $error("header version wrong");
	a_hdr_next: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		hdr_read |=> cfg_rdata_o[31:20] == ($past(dsn_structure_enable_i) ? 12'h140 : 12'h150))
		else $error("next pointer wrong");
	a_stat_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i || por_rst_i)
		stat_clear_req |=> ##1 !err_pending_o[12]) else $error("status clear failed");
	a_rsvd_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cfg_rd_i && cfg_addr_i != aerreg_pkg::HDR_OFF) |=> cfg_rdata_o[31:21] == 11'h000 && cfg_rdata_o[3:0] == 4'h0)
		else $error("reserved bits not zero");
	a_mask_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i || por_rst_i)
		(st.mask[14]) |=> !err_pending_o[14]) else $error("masked error reported");

endmodule // aerreg_top

// >>> sim/aerreg_host.sv
// Purpose: host configuration access model for the error register bank
// Assumes: one access at a time, strobes last one cycle
// Notes: released address and data show the inverse of the last value; byte enables keep the last value
`timescale 1ns/1ns
module aerreg_host (
	// clock
	input wire logic clk_i,
	// configuration access
	output logic cfg_rd_o,
	output logic cfg_wr_o,
	output logic [11:0] cfg_addr_o,
	output logic [3:0] cfg_be_o,
	output logic [31:0] cfg_wdata_o,
	input wire logic [31:0] cfg_rdata_i,
	input wire logic cfg_rvalid_i
);
	initial begin
		{cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
	end

	task automatic acc(input bit w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
		output logic [31:0] q, output logic v);
		@(posedge clk_i);
		#1;
		{cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {!w, w, a, b, d};
		@(posedge clk_i);
		#1;
		q = cfg_rdata_i;
		v = cfg_rvalid_i;
		{cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_wdata_o} = {2'b00, ~a, ~d};
	endtask
endmodule // aerreg_host

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the error reporting register bank
// Assumes: read answer one cycle after the strobe, outputs settle within three cycles
// Notes: one scenario lands an event and a status clear on the same edge; the event must win
`timescale 1ns/1ns
module tb_top;
	localparam logic [31:0] SUP = 32'h0017_D010;
	localparam logic [31:0] FIX1 = 32'h0000_2020;
	logic clk_i, sys_rst_i, por_rst_i, dsn, rd, wr, rv, v;
	logic [11:0] addr;
	logic [3:0] be;
	logic [31:0] wd, rdat, ev, pend, fatal, m_stat, m_mask, m_sev, q, bm;
	int n_fail, cmp_count, seed, cyc, r;

	aerreg_top aerreg_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i), .cfg_rd_i(rd),
		.cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
		.cfg_rvalid_o(rv), .dsn_structure_enable_i(dsn), .err_event_i(ev), .err_pending_o(pend),
		.err_fatal_o(fatal));
	aerreg_host aerreg_host_i (.clk_i(clk_i), .cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_addr_o(addr),
		.cfg_be_o(be), .cfg_wdata_o(wd), .cfg_rdata_i(rdat), .cfg_rvalid_i(rv));

	// ------------------------------------------------------------
	// clock, timeout, checking
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		aerreg_host_i.acc(1'b0, a, 4'hF, 32'h0, q, v);
		chk("rvalid", 32'h1, {31'h0, v});
		chk("rdata", e, q);
	endtask
	// model follows each write; only supported bits may move
	task wrc(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		aerreg_host_i.acc(1'b1, a, b, d, q, v);
		chk("write rvalid", 32'h0, {31'h0, v});
		if (a == 12'h104) m_stat = m_stat & ~(d & bm & SUP);
		if (a == 12'h108) m_mask = ((m_mask & ~bm) | (d & bm)) & SUP;
		if (a == 12'h10C) m_sev = (((m_sev & ~bm) | (d & bm)) & SUP) | FIX1;
	endtask
	task evt(input logic [31:0] e);
		@(posedge clk_i);
		#1;
		ev = e;
		@(posedge clk_i);
		#1;
		ev = 32'h0;
		m_stat = m_stat | (e & SUP);
	endtask
	task regs;
		rdc(12'h100, {dsn ? 12'h140 : 12'h150, 4'h1, 16'h0001});
		rdc(12'h104, m_stat);
		rdc(12'h108, m_mask);
		rdc(12'h10C, m_sev);
		rdc(12'h110, 32'h0);
		repeat (3) @(posedge clk_i);
		#1;
		chk("pending", m_stat & ~m_mask, pend);
		chk("fatal", m_stat & ~m_mask & m_sev, fatal);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{sys_rst_i, por_rst_i, dsn, ev, n_fail, cmp_count, seed, cyc} = {3'b111, 32'h0, 32'd0, 32'd0, 32'd15, 32'd0};
		{m_stat, m_mask, m_sev} = {64'h0, 32'h0006_2030};
		repeat (2) @(posedge clk_i);
		#1;
		{sys_rst_i, por_rst_i} = 2'b00;
		regs();
		$display("test reset values done");
		dsn = 1'b0;
		wrc(12'h100, 4'hF, 32'hFFFF_FFFF);
		wrc(12'h108, 4'hF, 32'hFFFF_FFFF);
		wrc(12'h10C, 4'hF, 32'h0);
		evt(32'hFFFF_FFFF);
		regs();
		$display("test fixed bits done");
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			dsn = r[8];
			if (r[1:0] == 2'd0) evt($random(seed));
			else wrc(12'h100 + {8'h0, r[1:0], 2'b00}, r[7:4], $random(seed));
			regs();
		end
		$display("test random traffic done");
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		regs();
		$display("test sticky through reset done");
		por_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		por_rst_i = 1'b0;
		{m_stat, m_mask, m_sev} = {64'h0, 32'h0006_2030};
		regs();
		$display("test power-on clear done");
		evt(32'h0000_C000);
		// clear of every lane and events on 4 and 12 taken at the same edge
		fork
			aerreg_host_i.acc(1'b1, 12'h104, 4'hF, 32'hFFFF_FFFF, q, v);
			evt(32'h0000_1010);
		join
		m_stat = 32'h0000_1010;
		regs();
		$display("test set over clear done");
		wrap_up();
	end
endmodule // tb_top
